// >>> brake_seq_map.svh
`ifndef BRAKE_SEQ_MAP_SVH
`define BRAKE_SEQ_MAP_SVH
`define CLK_MHZ 200
`define TICK_MS 10
`define IDX_ZERO_SPEED 14'h0680
`define IDX_START_CUR 14'h0681
`define IDX_STOP_CUR 14'h0682
`define IDX_START_HOLD 14'h0683
`define IDX_STOP_HOLD 14'h0684
`define IDX_BRK_REL 14'h0685
`define IDX_BRK_CLS 14'h0686
`define IDX_RUN_DLY 14'h0687
`define IDX_CONT_DLY 14'h0688
`define IDX_CTRL 14'h0689
`define IDX_STAT 14'h068a
`define CUR_RST 16'h0032
`define START_HOLD_RST 16'h0028
`define STOP_HOLD_RST 16'h003c
`define BRK_REL_RST 16'h0014
`define BRK_CLS_RST 16'h000a
`define RUN_DLY_RST 16'h000a
`define CONT_DLY_RST 16'h000a
`define ZS_DEF_OPEN 16'h0064
`define ZS_DEF_CLOSED 16'h0000
`define MODE_RST 2'h0
`define CTRL_STOP_BIT 4
`endif

// >>> brake_seq_pkg.sv
package brake_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN_DLY = 3'b001,
        ST_START = 3'b010,
        ST_RIDE = 3'b011,
        ST_STOP = 3'b100,
        ST_CONT = 3'b101
    } seq_state_e;
    typedef enum logic [1:0] {
        MODE_VF = 2'b00,
        MODE_OLV = 2'b01,
        MODE_CLV = 2'b10,
        MODE_CLOSED_LOOP_VECTOR_MAGNET_MOTOR = 2'b11
    } control_mode_e;
    typedef struct packed {
        logic run;
        logic inject;
        logic lock;
        logic brake_release;
        logic contactor_on;
    } drive_cmd_s;
    typedef logic [15:0] setting_t;
endpackage

// >>> elevator_brake_sequencer.sv
`timescale 1ns/1ps
`include "brake_seq_map.svh"
module elevator_brake_sequencer
    import brake_seq_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_MS * 1000 * `CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic travel_up,
    input wire logic travel_down,
    input wire logic [15:0] output_speed,
    output drive_cmd_s drive_cmd,
    output setting_t inject_current
);
    localparam int NCFG = 9;
    localparam setting_t CFG_RST [NCFG] = '{16'h0000, `CUR_RST, `CUR_RST, `START_HOLD_RST,
        `STOP_HOLD_RST, `BRK_REL_RST, `BRK_CLS_RST, `RUN_DLY_RST, `CONT_DLY_RST};

    setting_t cfg_reg [NCFG];
    logic zs_written_reg;
    control_mode_e mode_reg;
    logic coast_reg;
    seq_state_e state_reg, state_next;
    logic [21:0] presc_reg;
    logic tick;
    setting_t phase_ticks_reg, brake_ticks_reg;
    logic [2:0] up_sync_reg, dn_sync_reg;
    logic up_reg, dn_reg;
    logic closed_loop, phase_done, brake_clr;
    setting_t zs_thr, close_eff;
    logic [13:0] idx;
    logic setup_rd, access_wr, idx_ok;

    assign idx = paddr[15:2];
    assign setup_rd = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign idx_ok = (paddr[1:0] == 2'h0) && idx >= `IDX_ZERO_SPEED && idx <= `IDX_STAT;
    assign pslverr = psel && penable && !idx_ok;
    assign closed_loop = mode_reg == MODE_CLV || mode_reg == MODE_CLOSED_LOOP_VECTOR_MAGNET_MOTOR;

    // Unwritten threshold tracks the mode default
    always_comb begin
        if (zs_written_reg) begin
            zs_thr = cfg_reg[0];
        end else if (closed_loop) begin
            zs_thr = `ZS_DEF_CLOSED;
        end else begin
            zs_thr = `ZS_DEF_OPEN;
        end
    end

    // Close delay may never outlast the stop hold
    assign close_eff = (cfg_reg[6] > cfg_reg[4]) ? cfg_reg[4] : cfg_reg[6];

    genvar gi;
    generate
        for (gi = 0; gi < NCFG; gi++) begin : g_cfg
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cfg_reg[gi] <= CFG_RST[gi];
                end else if (access_wr && idx_ok && idx == `IDX_ZERO_SPEED + 14'(gi)) begin
                    cfg_reg[gi] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zs_written_reg <= 1'b0;
        end else if (access_wr && idx_ok && idx == `IDX_ZERO_SPEED) begin
            zs_written_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= control_mode_e'(`MODE_RST);
            coast_reg <= 1'b0;
        end else if (access_wr && idx_ok && idx == `IDX_CTRL) begin
            mode_reg <= control_mode_e'(pwdata[1:0]);
            coast_reg <= pwdata[`CTRL_STOP_BIT];
        end
    end

    // Read data latched in setup so the access phase needs no wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata <= 32'h0000_0000;
            if (idx_ok && idx <= `IDX_CONT_DLY) begin
                prdata[15:0] <= (idx == `IDX_ZERO_SPEED) ? zs_thr : cfg_reg[4'(idx - `IDX_ZERO_SPEED)];
            end else if (idx_ok && idx == `IDX_CTRL) begin
                prdata[1:0] <= mode_reg;
                prdata[`CTRL_STOP_BIT] <= coast_reg;
            end else if (idx_ok) begin
                prdata[2:0] <= state_reg;
                prdata[7:3] <= drive_cmd;
            end
        end
    end

    // Pins: a change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_sync_reg <= 3'h0;
            dn_sync_reg <= 3'h0;
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else begin
            up_sync_reg <= {up_sync_reg[1:0], travel_up};
            dn_sync_reg <= {dn_sync_reg[1:0], travel_down};
            if (up_sync_reg[1] == up_sync_reg[2]) begin
                up_reg <= up_sync_reg[2];
            end
            if (dn_sync_reg[1] == dn_sync_reg[2]) begin
                dn_reg <= dn_sync_reg[2];
            end
        end
    end

    // Prescaler restarts on each phase entry so phases are exact
    assign tick = presc_reg == 22'(TICK_CYCLES - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_reg <= 22'h0;
        end else if (state_next != state_reg || tick) begin
            presc_reg <= 22'h0;
        end else begin
            presc_reg <= presc_reg + 22'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_ticks_reg <= 16'h0;
        end else if (state_next != state_reg) begin
            phase_ticks_reg <= 16'h0;
        end else if (tick && phase_ticks_reg != 16'hffff) begin
            phase_ticks_reg <= phase_ticks_reg + 16'h1;
        end
    end

    // Brake timer spans start hold into the ride
    assign brake_clr = (state_next == ST_START && state_reg != ST_START)
        || (state_next == ST_RIDE && state_reg == ST_RUN_DLY)
        || (state_next == ST_STOP && state_reg != ST_STOP);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            brake_ticks_reg <= 16'h0;
        end else if (brake_clr) begin
            brake_ticks_reg <= 16'h0;
        end else if (tick && brake_ticks_reg != 16'hffff) begin
            brake_ticks_reg <= brake_ticks_reg + 16'h1;
        end
    end

    always_comb begin
        case (state_reg)
            ST_RUN_DLY: phase_done = phase_ticks_reg >= cfg_reg[7];
            ST_START: phase_done = phase_ticks_reg >= cfg_reg[3];
            ST_STOP: phase_done = phase_ticks_reg >= cfg_reg[4];
            ST_CONT: phase_done = phase_ticks_reg >= cfg_reg[8];
            default: phase_done = 1'b0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (up_reg || dn_reg) begin
                    state_next = ST_RUN_DLY;
                end
            end
            ST_RUN_DLY: begin
                if (phase_done) begin
                    state_next = (cfg_reg[3] == 16'h0) ? ST_RIDE : ST_START;
                end
            end
            ST_START: begin
                if (phase_done) begin
                    state_next = ST_RIDE;
                end
            end
            ST_RIDE: begin
                if (!up_reg && !dn_reg) begin
                    if (coast_reg) begin
                        state_next = ST_CONT;
                    end else if (output_speed <= zs_thr) begin
                        state_next = (cfg_reg[4] == 16'h0) ? ST_CONT : ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (phase_done) begin
                    state_next = ST_CONT;
                end
            end
            ST_CONT: begin
                if (phase_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_cmd.run <= 1'b0;
            drive_cmd.inject <= 1'b0;
            drive_cmd.lock <= 1'b0;
            drive_cmd.contactor_on <= 1'b0;
        end else begin
            drive_cmd.run <= state_next inside {ST_START, ST_RIDE, ST_STOP};
            drive_cmd.inject <= state_next inside {ST_START, ST_STOP} && !closed_loop;
            drive_cmd.lock <= state_next inside {ST_START, ST_STOP} && closed_loop;
            drive_cmd.contactor_on <= state_next != ST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inject_current <= 16'h0;
        end else if (state_next == ST_START && !closed_loop) begin
            inject_current <= cfg_reg[1];
        end else if (state_next == ST_STOP && !closed_loop) begin
            inject_current <= cfg_reg[2];
        end else begin
            inject_current <= 16'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_cmd.brake_release <= 1'b0;
        end else begin
            case (state_reg)
                ST_START, ST_RIDE: begin
                    if (brake_ticks_reg >= cfg_reg[5]) begin
                        drive_cmd.brake_release <= 1'b1;
                    end
                end
                ST_STOP: begin
                    if (brake_ticks_reg >= close_eff) begin
                        drive_cmd.brake_release <= 1'b0;
                    end
                end
                default: drive_cmd.brake_release <= 1'b0;
            endcase
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ride_stopping;
        state_reg == ST_RIDE && !up_reg && !dn_reg && !coast_reg;
    endsequence
    sequence s_at_zero_speed;
        output_speed <= zs_thr && cfg_reg[4] != 16'h0;
    endsequence

    a_zero_speed_stop: assert property (
        (s_ride_stopping and s_at_zero_speed) |=> state_reg == ST_STOP
            && (drive_cmd.inject || drive_cmd.lock))
        else $error("zero speed did not start stop hold");
    a_start_inj_current: assert property (
        state_reg == ST_START && drive_cmd.inject |-> inject_current == cfg_reg[1] || $changed(cfg_reg[1]))
        else $error("start current differs from setting");
    a_stop_inj_current: assert property (
        state_reg == ST_STOP && drive_cmd.inject |-> inject_current == cfg_reg[2] || $changed(cfg_reg[2]))
        else $error("stop current differs from setting");
    a_start_hold_skip: assert property (
        state_reg == ST_RUN_DLY && phase_done && cfg_reg[3] == 16'h0 |=> state_reg == ST_RIDE)
        else $error("zero start hold not skipped");
    a_stop_hold_len: assert property (
        $fell(state_reg == ST_STOP) |-> $past(phase_ticks_reg) >= $past(cfg_reg[4]))
        else $error("stop hold ended early");
    a_lock_mode: assert property (
        drive_cmd.lock |-> closed_loop && !drive_cmd.inject)
        else $error("position lock outside closed loop");
    a_brake_release: assert property (
        $rose(drive_cmd.brake_release) |-> $past(brake_ticks_reg) >= $past(cfg_reg[5]))
        else $error("brake released before its delay");
    a_brake_close: assert property (
        $fell(drive_cmd.brake_release) && $past(state_reg) == ST_STOP
            |-> $past(brake_ticks_reg) >= $past(close_eff) && close_eff <= cfg_reg[4])
        else $error("brake closed before its delay");
    a_run_delay: assert property (
        $rose(drive_cmd.run) |-> $past(state_reg) == ST_RUN_DLY
            && $past(phase_ticks_reg) >= $past(cfg_reg[7]))
        else $error("run command set before delay");
    a_contactor_open: assert property (
        $fell(drive_cmd.contactor_on) |-> $past(state_reg) == ST_CONT
            && $past(phase_ticks_reg) >= $past(cfg_reg[8]) && !drive_cmd.brake_release)
        else $error("contactor opened before delay");
    a_zs_default: assert property (
        !zs_written_reg && closed_loop |-> zs_thr == `ZS_DEF_CLOSED)
        else $error("threshold default ignores mode");
    a_phase_restart: assert property (
        state_reg != $past(state_reg) |-> phase_ticks_reg == 16'h0 && presc_reg == 22'h0)
        else $error("phase timer not restarted");
endmodule // elevator_brake_sequencer

// >>> elevator_ctrl_model.sv
`timescale 1ns/1ps
module elevator_ctrl_model
    import brake_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic call_up,
    input wire logic call_down,
    input wire drive_cmd_s drive_cmd,
    output logic travel_up,
    output logic travel_down,
    output logic [15:0] output_speed
);
    // Command held until the run command is set, then dropped as the stop request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            travel_up <= 1'b0;
            travel_down <= 1'b0;
        end else if (drive_cmd.run) begin
            travel_up <= 1'b0;
            travel_down <= 1'b0;
        end else if (call_up) begin
            travel_up <= 1'b1;
        end else if (call_down) begin
            travel_down <= 1'b1;
        end
    end

    // Crude deceleration so the zero-speed level is crossed a few cycles in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_speed <= 16'h0000;
        end else if (travel_up || travel_down) begin
            output_speed <= 16'h2710;
        end else if (output_speed > 16'h0400) begin
            output_speed <= output_speed - 16'h0400;
        end else begin
            output_speed <= 16'h0000;
        end
    end
endmodule // elevator_ctrl_model

// >>> tb_elevator_brake_sequencer.sv
`timescale 1ns/1ps
`include "brake_seq_map.svh"
module tb_elevator_brake_sequencer
    import brake_seq_pkg::*;
;
    localparam int T = 4;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, up, dn, call_up, call_down, e;
    logic [15:0] paddr, spd;
    logic [31:0] pwdata, prdata, r;
    drive_cmd_s drive_cmd;
    setting_t inject_current;
    int err_count, tests_run;
    logic [15:0] defs [9] = '{`ZS_DEF_OPEN, `CUR_RST, `CUR_RST, `START_HOLD_RST, `STOP_HOLD_RST,
                             `BRK_REL_RST, `BRK_CLS_RST, `RUN_DLY_RST, `CONT_DLY_RST};

    elevator_brake_sequencer #(.TICK_CYCLES(T)) uut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .travel_up(up), .travel_down(dn), .output_speed(spd),
        .drive_cmd(drive_cmd), .inject_current(inject_current));
    elevator_ctrl_model far (.clk(clk), .rst(rst), .call_up(call_up), .call_down(call_down),
        .drive_cmd(drive_cmd), .travel_up(up), .travel_down(dn), .output_speed(spd));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task results;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // Window allows for registered outputs and phase-entry latency
    task chkr(input string name, input int lo, input int got);
        tests_run++;
        if (got < lo - 1 || got > lo + 3) begin
            $display("MISMATCH %s expected %0d seen %0d", name, lo, got);
            err_count++;
        end
    endtask

    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        @(posedge clk);
    endtask

    task wr(input logic [13:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask

    task rdc(input string name, input logic [13:0] i, input logic [31:0] exp);
        apb(1'b0, {i, 2'b00}, 32'h0);
        chk(name, exp, r);
    endtask

    task ride(input logic [1:0] mode, input int sh, input int ph, input logic down);
        int t_con, t_run, t_brk, t_stop, t_off, t_rf, c, n_hold, n_lock;
        logic [15:0] sp, cur_s, cur_p;
        drive_cmd_s p;
        t_con = 0;
        t_run = 0;
        t_brk = 0;
        t_stop = 0;
        t_off = 0;
        t_rf = 0;
        n_hold = 0;
        n_lock = 0;
        sp = 16'hffff;
        // Sentinels so a missing capture shows up as a mismatch
        cur_s = 16'hffff;
        cur_p = 16'hffff;
        wr(`IDX_CTRL, {30'h0, mode});
        wr(`IDX_START_HOLD, sh);
        wr(`IDX_STOP_HOLD, ph);
        if (down) call_down <= 1'b1;
        else call_up <= 1'b1;
        @(posedge clk);
        call_up <= 1'b0;
        call_down <= 1'b0;
        p = drive_cmd;
        for (c = 0; c < 2000; c++) begin
            @(posedge clk);
            #1;
            if (drive_cmd.contactor_on && !p.contactor_on) t_con = c;
            if (drive_cmd.run && !p.run) t_run = c;
            if (!drive_cmd.run && p.run) t_rf = c;
            if (drive_cmd.brake_release && !p.brake_release) t_brk = c;
            if (!drive_cmd.brake_release && p.brake_release) t_off = c;
            if ((drive_cmd.inject || drive_cmd.lock) && !(p.inject || p.lock) && !drive_cmd.brake_release) begin
                cur_s = inject_current;
            end
            if ((drive_cmd.inject || drive_cmd.lock) && !(p.inject || p.lock) && drive_cmd.brake_release) begin
                t_stop = c;
                sp = spd;
                cur_p = inject_current;
            end
            n_hold += int'(drive_cmd.inject || drive_cmd.lock);
            n_lock += int'(drive_cmd.lock);
            if (!drive_cmd.contactor_on && p.contactor_on) break;
            p = drive_cmd;
        end
        if (c == 2000) begin
            err_count++;
            results();
        end
        chkr("run delay", 2 * T, t_run - t_con);
        chkr("brake release", T, t_brk - t_run);
        chkr("brake close", T, t_off - t_stop);
        chkr("contactor open", T, c - t_rf);
        chkr("hold cycles", (sh + ph) * T, n_hold);
        chk("lock used", mode[1], n_lock != 0);
        chk("stop speed", 1, sp <= (mode[1] ? `ZS_DEF_CLOSED : `ZS_DEF_OPEN));
        if (sh != 0) chk("start current", mode[1] ? 32'h0 : 32'h20, cur_s);
        chk("stop current", mode[1] ? 32'h0 : 32'h30, cur_p);
        repeat (4) @(posedge clk);
    endtask

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, call_up, call_down} = 5'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        err_count = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) rdc("reset value", `IDX_ZERO_SPEED + 14'(i), {16'h0, defs[i]});
        apb(1'b0, {14'h068b, 2'b00}, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        wr(`IDX_CTRL, 32'h11);
        rdc("control readback", `IDX_CTRL, 32'h11);
        rdc("open loop threshold", `IDX_ZERO_SPEED, {16'h0, `ZS_DEF_OPEN});
        rdc("idle status", `IDX_STAT, 32'h0);
        wr(`IDX_CTRL, 32'h2);
        rdc("closed loop threshold", `IDX_ZERO_SPEED, {16'h0, `ZS_DEF_CLOSED});
        wr(`IDX_START_CUR, 32'h20);
        wr(`IDX_STOP_CUR, 32'h30);
        rdc("start current reg", `IDX_START_CUR, 32'h20);
        wr(`IDX_RUN_DLY, 32'h2);
        wr(`IDX_BRK_REL, 32'h1);
        wr(`IDX_BRK_CLS, 32'h1);
        wr(`IDX_CONT_DLY, 32'h1);
        ride(2'h0, 3, 2, 1'b0);
        ride(2'h2, 0, 2, 1'b1);
        ride(2'h3, 2, 3, 1'b0);
        // Written threshold overrides the mode default; upper half reads zero
        wr(`IDX_ZERO_SPEED, 32'hffff_1234);
        rdc("written threshold", `IDX_ZERO_SPEED, 32'h0000_1234);
        results();
    end
endmodule // tb_elevator_brake_sequencer
